// >>> pkg/tpc_pkg.sv
/*
 Package for the timer prescaler and capture block: register map,
 field layout, reset values, clock select codes and bus types.
 Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
*/
package tpc_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_RUN = 8'h00;
	localparam logic [7:0] OFS_CLKCFG = 8'h04;
	localparam logic [7:0] OFS_CAP_A = 8'h08;
	localparam logic [7:0] OFS_CAP_B = 8'h0C;
	localparam logic [7:0] OFS_PSC = 8'h10;
	localparam int RUN_BIT = 0;
	localparam int PRCK_LSB = 0;
	localparam int PRCK_W = 3;
	localparam int GEAR_LSB = 4;
	localparam int GEAR_W = 3;
	localparam int FPSEL_LSB = 8;
	localparam int FPSEL_W = 2;
	localparam int CLKSRC_BIT = 12;
	localparam int PSC_W = 4;
	localparam int GEAR_CNT_W = 4;
	localparam int PER_CNT_W = 5;
	localparam logic [31:0] CAP_RST = 32'h00000000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [1:0] FPSEL_GEAR = 2'h0;
	localparam logic [2:0] PRCK_DIV1 = 3'h0;
	localparam logic [2:0] PRCK_DIV32 = 3'h5;
	localparam logic [2:0] GEAR_DIV1 = 3'h0;
	localparam logic [2:0] GEAR_DIV2 = 3'h4;
	localparam logic [2:0] GEAR_DIV4 = 3'h5;
	localparam logic [2:0] GEAR_DIV8 = 3'h6;
	localparam logic [2:0] GEAR_DIV16 = 3'h7;
	localparam int TICK2_BIT = 0;
	localparam int TICK8_BIT = 2;
	localparam int TICK32_BIT = 4;

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [31:0] writedata;
	} tpc_req_t;

	typedef struct packed {
		logic tick_div2;
		logic tick_div8;
		logic tick_div32;
	} tpc_tick_t;
endpackage

// >>> verilog/tpc_timer_prescaler_capture.sv
/*
 Prescaler and capture readout for one 16-bit timer channel.
 Assumes high_speed_clock and low_speed_clock arrive as single-cycle
 enables on clk, the counter runs outside, and capture strobes come
 from the capture trigger logic on clk.
*/
// The implementer's own choices: the address map and register access over Avalon-MM.
// Summary of operation
// R1: Two read-only 16-bit captures, upper zero
// R2: Four-bit prescaler clocks the up-counter
// R3: Input is low-speed or peripheral divided 1..32
// R4: Peripheral clock is geared or undivided high-speed
// R5: Run 1 counts; 0 clears and stops
// R6: Ticks at prescaler input over 2, 8, 32
// R7: Gear codes divide high-speed by 1..16
// R8: Every channel instance behaves identically
// R9: Software keeps ticks slower than system clock
// R10: Ticks are single-cycle enables on clk
`timescale 1ns/1ps
module tpc_timer_prescaler_capture #(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [tpc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic hs_clk_en,
	input wire logic ls_clk_en,
	input wire logic [CNT_W-1:0] up_counter,
	input wire logic capture_a_stb,
	input wire logic capture_b_stb,
	output tpc_pkg::tpc_tick_t ticks,
	output logic prescaler_run
);
	if (CNT_W != 16) begin
		$error("Capture registers hold exactly 16 bits");
	end

	tpc_pkg::tpc_req_t req;
	logic ack_r;
	logic [31:0] rdata_r;
	logic run_r;
	logic [2:0] prck_r;
	logic [2:0] gear_r;
	logic [1:0] fpsel_r;
	logic clksrc_r;
	logic [15:0] cap_a_r;
	logic [15:0] cap_b_r;
	logic [tpc_pkg::GEAR_CNT_W-1:0] gear_cnt_r;
	logic [tpc_pkg::PER_CNT_W-1:0] per_cnt_r;
	logic [tpc_pkg::PSC_W-1:0] psc_r;
	logic [tpc_pkg::PSC_W-1:0] psc_nxt;
	tpc_pkg::tpc_tick_t ticks_r;
	logic per_cnt_odd_r;
	logic hs_s1_r, hs_s2_r, ls_s1_r, ls_s2_r;

	assign req = '{read: avs_read, write: avs_write,
		address: avs_address, writedata: avs_writedata};

	// One wait cycle per access; the answer lands on the second edge
	wire bus_act = (req.read | req.write) & ~ack_r;
	wire wr_take = req.write & ack_r;
	wire rd_take = req.read & ~ack_r;
	wire sel_run = req.address == tpc_pkg::OFS_RUN;
	wire sel_cfg = req.address == tpc_pkg::OFS_CLKCFG;
	wire sel_cap_a = req.address == tpc_pkg::OFS_CAP_A;
	wire sel_cap_b = req.address == tpc_pkg::OFS_CAP_B;
	wire sel_psc = req.address == tpc_pkg::OFS_PSC;

	assign avs_waitrequest = (req.read | req.write) & ~ack_r;
	assign avs_readdata = rdata_r;

	wire [31:0] cfg_word = {19'h00000, clksrc_r, 2'h0, fpsel_r, 1'h0,
		gear_r, 1'h0, prck_r};
	wire [31:0] rd_mux = sel_run ? {31'h00000000, run_r} :
		sel_cfg ? cfg_word :
		sel_cap_a ? {16'h0000, cap_a_r} : // R1
		sel_cap_b ? {16'h0000, cap_b_r} : // R1
		sel_psc ? {28'h0000000, psc_r} :
		32'h00000000;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_r <= 1'b0;
			rdata_r <= tpc_pkg::CAP_RST;
		end else begin
			ack_r <= bus_act;
			if (rd_take)
				rdata_r <= rd_mux;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			run_r <= 1'b0;
			prck_r <= tpc_pkg::PRCK_DIV1;
			gear_r <= tpc_pkg::GEAR_DIV1;
			fpsel_r <= tpc_pkg::FPSEL_GEAR;
			clksrc_r <= 1'b0;
		end else if (wr_take) begin
			if (sel_run)
				run_r <= req.writedata[tpc_pkg::RUN_BIT]; // R5
			if (sel_cfg) begin
				prck_r <= req.writedata[tpc_pkg::PRCK_LSB +: 3];
				gear_r <= req.writedata[tpc_pkg::GEAR_LSB +: 3];
				fpsel_r <= req.writedata[tpc_pkg::FPSEL_LSB +: 2];
				clksrc_r <= req.writedata[tpc_pkg::CLKSRC_BIT];
			end
		end
	end

	// Snapshots of the external up-counter; reads have no side effect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cap_a_r <= tpc_pkg::CNT_RST; // R1
			cap_b_r <= tpc_pkg::CNT_RST;
		end else begin
			if (capture_a_stb)
				cap_a_r <= up_counter;
			if (capture_b_stb)
				cap_b_r <= up_counter;
		end
	end

	// Source enables come from another domain
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hs_s1_r <= 1'b0;
			hs_s2_r <= 1'b0;
			ls_s1_r <= 1'b0;
			ls_s2_r <= 1'b0;
		end else begin
			hs_s1_r <= hs_clk_en;
			hs_s2_r <= hs_s1_r;
			ls_s1_r <= ls_clk_en;
			ls_s2_r <= ls_s1_r;
		end
	end

	// Gear divider on the high-speed enable
	wire [tpc_pkg::GEAR_CNT_W-1:0] gear_mask =
		gear_r == tpc_pkg::GEAR_DIV2 ? 4'h1 :
		gear_r == tpc_pkg::GEAR_DIV4 ? 4'h3 :
		gear_r == tpc_pkg::GEAR_DIV8 ? 4'h7 :
		gear_r == tpc_pkg::GEAR_DIV16 ? 4'hF : 4'h0;
	wire gear_en = hs_s2_r & ((gear_cnt_r & gear_mask) == gear_mask); // R7
	wire periph_en = (fpsel_r == tpc_pkg::FPSEL_GEAR) ? gear_en :
		hs_s2_r; // R4

	// Peripheral divider 1..32; codes above 101 fall back to divide 32
	wire [2:0] prck_eff = (prck_r > tpc_pkg::PRCK_DIV32) ?
		tpc_pkg::PRCK_DIV32 : prck_r;
	wire [tpc_pkg::PER_CNT_W-1:0] per_mask =
		(5'h01 << prck_eff) - 5'h01;
	wire per_en = periph_en & ((per_cnt_r & per_mask) == per_mask); // R3
	wire psc_in = clksrc_r ? ls_s2_r : per_en; // R3

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gear_cnt_r <= 4'h0;
			per_cnt_r <= 5'h00;
		end else begin
			if (hs_s2_r)
				gear_cnt_r <= gear_cnt_r + 4'h1;
			if (periph_en)
				per_cnt_r <= per_cnt_r + 5'h01;
		end
	end

	// Stopped prescaler is held at zero
	assign psc_nxt = !run_r ? 4'h0 : psc_in ? psc_r + 4'h1 : psc_r; // R5 R2

	// Tick fires when all lower bits are ones on a counted input edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			psc_r <= 4'h0;
			ticks_r <= '0;
		end else begin
			psc_r <= psc_nxt;
			ticks_r.tick_div2 <= run_r & psc_in &
				(psc_r[tpc_pkg::TICK2_BIT:0] == 1'h1); // R6 R10
			ticks_r.tick_div8 <= run_r & psc_in &
				(psc_r[tpc_pkg::TICK8_BIT:0] == 3'h7); // R6 R10
			ticks_r.tick_div32 <= run_r & psc_in &
				(psc_r == 4'hF) & per_cnt_odd_r; // R6 R10
		end
	end

	// Fifth stage extends the four-bit prescaler for the divide-32 tick
	always_ff @(posedge clk) begin
		if (sys_rst)
			per_cnt_odd_r <= 1'b0;
		else if (!run_r)
			per_cnt_odd_r <= 1'b0;
		else if (psc_in && psc_r == 4'hF)
			per_cnt_odd_r <= ~per_cnt_odd_r;
	end

	assign ticks = ticks_r; // R8
	assign prescaler_run = run_r;

	property p_tick_pulse;
		@(posedge clk) disable iff (sys_rst)
		ticks_r.tick_div2 |=> !ticks_r.tick_div2;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) // R10
		else $error("div2 tick longer than one cycle");

	property p_stop_clears;
		@(posedge clk) disable iff (sys_rst)
		!run_r |=> psc_r == 4'h0;
	endproperty
	a_stop_clears: assert property (p_stop_clears) // R5
		else $error("prescaler not cleared when stopped");

	property p_no_tick_stopped;
		@(posedge clk) disable iff (sys_rst)
		!run_r |=> !ticks_r.tick_div2 && !ticks_r.tick_div8 &&
			!ticks_r.tick_div32;
	endproperty
	a_no_tick_stopped: assert property (p_no_tick_stopped) // R5
		else $error("tick while stopped");

	property p_div8_implies_div2;
		@(posedge clk) disable iff (sys_rst)
		ticks_r.tick_div8 |-> ticks_r.tick_div2;
	endproperty
	a_div8_implies_div2: assert property (p_div8_implies_div2) // R6
		else $error("div8 tick not aligned with div2");

	property p_div32_implies_div8;
		@(posedge clk) disable iff (sys_rst)
		ticks_r.tick_div32 |-> ticks_r.tick_div8;
	endproperty
	a_div32_implies_div8: assert property (p_div32_implies_div8) // R6
		else $error("div32 tick not aligned with div8");

	property p_cap_upper_zero;
		@(posedge clk) disable iff (sys_rst)
		rd_take && (sel_cap_a || sel_cap_b) |=> rdata_r[31:16] == 16'h0;
	endproperty
	a_cap_upper_zero: assert property (p_cap_upper_zero) // R1
		else $error("capture upper bits not zero");

	property p_cap_value;
		@(posedge clk) disable iff (sys_rst)
		rd_take && sel_cap_a |=> rdata_r[15:0] == $past(cap_a_r);
	endproperty
	a_cap_value: assert property (p_cap_value) // R1
		else $error("capture A read wrong");

	property p_undiv_src;
		@(posedge clk) disable iff (sys_rst)
		fpsel_r != tpc_pkg::FPSEL_GEAR && prck_r == 3'h0 &&
			!clksrc_r |-> psc_in == hs_s2_r;
	endproperty
	a_undiv_src: assert property (p_undiv_src) // R4
		else $error("undivided source not passed");

	property p_wait_one;
		@(posedge clk) disable iff (sys_rst)
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) // R1
		else $error("read answer not after one wait");

	property p_tick_on_edge;
		@(posedge clk) disable iff (sys_rst)
		ticks_r.tick_div2 |-> $past(psc_in) && $past(run_r);
	endproperty
	a_tick_on_edge: assert property (p_tick_on_edge) // R6
		else $error("tick high without input edge");

	property p_cap_b_value;
		@(posedge clk) disable iff (sys_rst)
		rd_take && sel_cap_b |=> rdata_r[15:0] == $past(cap_b_r);
	endproperty
	a_cap_b_value: assert property (p_cap_b_value) // R1
		else $error("capture B read wrong");

	property p_psc_step;
		@(posedge clk) disable iff (sys_rst)
		run_r && psc_in |=> psc_r == $past(psc_r) + 4'h1;
	endproperty
	a_psc_step: assert property (p_psc_step) // R2
		else $error("prescaler missed a counted edge");

	property p_psc_hold;
		@(posedge clk) disable iff (sys_rst)
		run_r && !psc_in |=> psc_r == $past(psc_r);
	endproperty
	a_psc_hold: assert property (p_psc_hold) // R2
		else $error("prescaler moved without an edge");

	property p_gear_pass;
		@(posedge clk) disable iff (sys_rst)
		gear_r == tpc_pkg::GEAR_DIV1 |-> gear_en == hs_s2_r;
	endproperty
	a_gear_pass: assert property (p_gear_pass) // R7
		else $error("undivided gear dropped an enable");

	property p_ls_src;
		@(posedge clk) disable iff (sys_rst)
		clksrc_r |-> psc_in == ls_s2_r;
	endproperty
	a_ls_src: assert property (p_ls_src) // R3
		else $error("low-speed source not passed");
endmodule

// >>> dv/tpc_timer_prescaler_capture_tb.sv
/*
 Self-checking bench for the timer prescaler and capture block.
 Assumes tpc_pkg and the design are compiled first; one 200 MHz clock.
*/
`timescale 1ns/1ps
module tpc_timer_prescaler_capture_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic hs_clk_en = 1'b0;
	logic ls_clk_en = 1'b0;
	logic [15:0] up_counter = 16'h0000;
	logic capture_a_stb = 1'b0;
	logic capture_b_stb = 1'b0;
	tpc_pkg::tpc_tick_t ticks;
	logic prescaler_run;
	logic [31:0] n2 = 32'h0;
	logic [31:0] n8 = 32'h0;
	logic [31:0] n32 = 32'h0;
	logic t2_q = 1'b0;
	int errors = 0;
	int check_count = 0;

	always #2.5 clk = ~clk;

	tpc_timer_prescaler_capture #(.CNT_W(16)) i_tpc_timer_prescaler_capture (
		.clk(clk),
		.sys_rst(sys_rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.hs_clk_en(hs_clk_en),
		.ls_clk_en(ls_clk_en),
		.up_counter(up_counter),
		.capture_a_stb(capture_a_stb),
		.capture_b_stb(capture_b_stb),
		.ticks(ticks),
		.prescaler_run(prescaler_run)
	);

	task automatic fail(input string msg);
		errors++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		check_count++;
		if (got !== exp)
			fail($sformatf("%s got %h exp %h", what, got, exp));
	endtask

	// Counted mid-cycle so registered ticks are settled
	always @(negedge clk) begin
		n2 = n2 + {31'h0, ticks.tick_div2 === 1'b1};
		n8 = n8 + {31'h0, ticks.tick_div8 === 1'b1};
		n32 = n32 + {31'h0, ticks.tick_div32 === 1'b1};
		if (ticks.tick_div2 === 1'b1 && t2_q === 1'b1)
			fail("tick_div2 wider than one cycle");
		t2_q = ticks.tick_div2;
	end

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		// Sampled at the edge, before the design's updates there land
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp, $sformatf("read %h", a));
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	// Per pass: two high-speed enables, one low-speed enable
	task automatic feed(input int n);
		repeat (n) begin
			hs_clk_en <= 1'b1;
			ls_clk_en <= 1'b1;
			@(posedge clk);
			hs_clk_en <= 1'b0;
			ls_clk_en <= 1'b0;
			@(posedge clk);
			hs_clk_en <= 1'b1;
			@(posedge clk);
			hs_clk_en <= 1'b0;
			@(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask

	function automatic logic [31:0] cfg(input logic [2:0] pr,
		input logic [2:0] gr, input logic [1:0] fp, input logic src);
		cfg = 32'h0;
		cfg[tpc_pkg::PRCK_LSB +: 3] = pr;
		cfg[tpc_pkg::GEAR_LSB +: 3] = gr;
		cfg[tpc_pkg::FPSEL_LSB +: 2] = fp;
		cfg[tpc_pkg::CLKSRC_BIT] = src;
	endfunction

	// Every setting is fed so that exactly 64 edges reach the prescaler
	task automatic measure(input logic [31:0] c, input int n);
		logic [31:0] b2, b8, b32;
		wr(tpc_pkg::OFS_RUN, 32'h0);
		wr(tpc_pkg::OFS_CLKCFG, c);
		wr(tpc_pkg::OFS_RUN, 32'h1);
		b2 = n2;
		b8 = n8;
		b32 = n32;
		feed(n);
		chk(n2 - b2, 32'h20, "div2 ticks");
		chk(n8 - b8, 32'h8, "div8 ticks");
		chk(n32 - b32, 32'h2, "div32 ticks");
	endtask

	task automatic t_reset;
		rd(tpc_pkg::OFS_CAP_A, 32'h0);
		rd(tpc_pkg::OFS_CAP_B, 32'h0);
		rd(tpc_pkg::OFS_RUN, 32'h0);
		rd(tpc_pkg::OFS_CLKCFG, 32'h0);
		rd(8'h14, 32'h0);
		chk({31'h0, prescaler_run}, 32'h0, "run after reset");
	endtask

	task automatic t_capture;
		up_counter <= 16'hA5C3;
		capture_a_stb <= 1'b1;
		@(posedge clk);
		up_counter <= 16'hFFFF;
		capture_a_stb <= 1'b0;
		capture_b_stb <= 1'b1;
		@(posedge clk);
		capture_b_stb <= 1'b0;
		up_counter <= 16'h1234;
		@(posedge clk);
		wr(tpc_pkg::OFS_CAP_A, 32'hFFFFFFFF);
		rd(tpc_pkg::OFS_CAP_A, 32'h0000A5C3);
		rd(tpc_pkg::OFS_CAP_B, 32'h0000FFFF);
	endtask

	task automatic t_run_stop;
		logic [31:0] b2;
		wr(tpc_pkg::OFS_CLKCFG, 32'h0);
		wr(tpc_pkg::OFS_RUN, 32'h1);
		chk({31'h0, prescaler_run}, 32'h1, "run set");
		feed(3);
		rd(tpc_pkg::OFS_PSC, 32'h6);
		wr(tpc_pkg::OFS_RUN, 32'h0);
		rd(tpc_pkg::OFS_PSC, 32'h0);
		chk({31'h0, prescaler_run}, 32'h0, "run clear");
		b2 = n2;
		feed(4);
		chk(n2 - b2, 32'h0, "ticks while stopped");
	endtask

	task automatic t_clocks;
		logic [2:0] gears [5];
		gears = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
		for (int c = 0; c < 6; c++)
			measure(cfg(c[2:0], 3'h0, 2'h0, 1'b0), 32 << c);
		for (int g = 0; g < 5; g++)
			measure(cfg(3'h0, gears[g], 2'h0, 1'b0), 32 << g);
		measure(cfg(3'h6, 3'h0, 2'h0, 1'b0), 1024);
		measure(cfg(3'h0, 3'h3, 2'h0, 1'b0), 32);
		measure(cfg(3'h0, 3'h7, 2'h1, 1'b0), 32);
		measure(cfg(3'h0, 3'h0, 2'h0, 1'b1), 64);
	endtask

	task automatic wrap_up;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#200000;
		fail("watchdog expired");
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_capture();
		t_run_stop();
		t_clocks();
		wrap_up();
	end
endmodule
